/* inc/csc_pkg.sv */
package csc_pkg;

  // Register offsets, equal to their byte addresses on the register port
  localparam logic [7:0] CSC_OFS_STOP       = 8'h02;
  localparam logic [7:0] CSC_OFS_START      = 8'h03;
  localparam logic [7:0] CSC_OFS_KNEE       = 8'h04;
  localparam logic [7:0] CSC_OFS_UPPER      = 8'h05;
  localparam logic [7:0] CSC_OFS_BASE_HI    = 8'h06;
  localparam logic [7:0] CSC_OFS_BASE_LO    = 8'h07;
  localparam logic [7:0] CSC_OFS_SLOPE1_HI  = 8'h08;
  localparam logic [7:0] CSC_OFS_SLOPE1_LO  = 8'h09;
  localparam logic [7:0] CSC_OFS_SLOPE2_HI  = 8'h0a;
  localparam logic [7:0] CSC_OFS_SLOPE2_LO  = 8'h0b;
  localparam logic [7:0] CSC_OFS_STATUS     = 8'h20;

  // Index range of the configuration array
  localparam int CSC_CFG_FIRST = 2;
  localparam int CSC_CFG_LAST  = 11;

  // Field positions
  localparam int CSC_KEEP_BIT     = 7;
  localparam int CSC_HANDOVER_BIT = 1;
  localparam int CSC_FULLZERO_BIT = 0;
  localparam int CSC_OLSEL_BIT    = 0;
  localparam int CSC_STAT_DIRECT  = 0;
  localparam int CSC_STAT_FALLING = 1;

  // Values after reset
  localparam logic [7:0] CSC_CFG_RST = 8'h00;

  // Curve arithmetic constants
  localparam int CSC_KNEE_OFFSET = 257;
  localparam int CSC_SLOPE_SHIFT = 6;

  // Hand-over state, one-hot
  typedef enum logic [1:0] {
    CSC_CLOSED = 2'b01,
    CSC_DIRECT = 2'b10
  } csc_loop_t;

endpackage : csc_pkg

/* rtl/csc_segment.sv */
module csc_segment
  import csc_pkg::*;
#(
  parameter int SLOPE_W = 14,
  parameter int SPAN_W  = 10,
  parameter int OUT_W   = 19
) (
  input  wire logic [SLOPE_W-1:0] slope,
  input  wire logic [SPAN_W-1:0]  span,
  output logic      [OUT_W-1:0]   rise
);

  localparam int PW = SLOPE_W + SPAN_W;

  logic [PW-1:0] product;

  // Slope is 64 times rpm per command step, so drop six bits after the product
  assign product = PW'(slope) * PW'(span);
  assign rise    = OUT_W'(product >> CSC_SLOPE_SHIFT);

endmodule : csc_segment

/* rtl/csc_speed_curve.sv */
// Summary of operation
// R1: Curve runs when method select bit is 0; selecting open loop parks it.
// R2: Upper knee point is the 8-bit code plus 257, in 1/512 steps.
// R3: Start point is its code; stop point is its 7-bit code doubled.
// R4: Twelve-bit base speed, split over two registers, is the speed at start.
// R5: Above start, speed rises by slope times command steps divided by 64.
// R6: With hand-over, return to closed loop at knee minus twice the sum of hysteresis and one.
// R7: Software programs hysteresis as percent over 0.4 minus one.
// R8: Return point lies 0.4 to 6.4 percent below the upper knee.
// R9: Default low behaviour: zero up to stop, rising zero, falling base between.
// R10: Keep-running bit gives base between stop and start, base or maximum below.
// R11: Full-speed-at-zero without keep-running gives maximum at zero, zero up to stop.
// R12: With hand-over enabled, a maximum-speed low case drives full output as well as maximum speed.
// R13: Software enables hand-over and sets hysteresis to follow input above knee.
// R14: Nonzero knee point code, doubled, splits the curve into two slopes.
// R15: Between start and knee point the first slope applies.
// R16: Above the knee point the second slope, from registers 10 and 11, applies.
// R17: Software places knee point between start and upper knee, or writes 0.
// R18: Knee point works together with hand-over and low-command options.
// R19: Without hand-over the speed is clamped at the upper knee value.
module csc_speed_curve
  import csc_pkg::*;
#(
  parameter int CMD_W   = 10,
  parameter int RPM_W   = 19,
  parameter int SLOPE_W = 14
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [CMD_W-1:0] speed_command,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_we,
  output logic      [7:0]       reg_rdata,
  output logic      [RPM_W-1:0] target_rpm,
  output logic                  full_output,
  output logic                  direct_follow,
  output logic                  curve_active
);

  // Configuration bytes, addressed by their offset
  logic [7:0]       cfg [CSC_CFG_FIRST:CSC_CFG_LAST];
  csc_loop_t        loop_state;
  csc_loop_t        next_loop_state;
  logic [CMD_W-1:0] prev_cmd;
  logic             falling;
  logic             next_falling;
  logic [RPM_W-1:0] next_target;
  logic             next_full;

  // Named fields
  logic [6:0]         stop_threshold_code;
  logic               keep_running_low_cmd;
  logic [7:0]         start_threshold_code;
  logic [7:0]         knee_point_code;
  logic [7:0]         upper_knee_code;
  logic [11:0]        base_speed_rpm;
  logic [3:0]         handover_hysteresis;
  logic [SLOPE_W-1:0] first_slope;
  logic [SLOPE_W-1:0] second_slope;
  logic               control_method_select_handover_en;
  logic               full_speed_at_zero;
  logic               control_method_select;

  assign stop_threshold_code   = cfg[CSC_OFS_STOP][6:0];                   // R3
  assign keep_running_low_cmd  = cfg[CSC_OFS_STOP][CSC_KEEP_BIT];
  assign start_threshold_code  = cfg[CSC_OFS_START];
  assign knee_point_code       = cfg[CSC_OFS_KNEE];
  assign upper_knee_code       = cfg[CSC_OFS_UPPER];
  assign base_speed_rpm        = {cfg[CSC_OFS_BASE_HI], cfg[CSC_OFS_BASE_LO][7:4]};      // R4
  assign handover_hysteresis   = cfg[CSC_OFS_BASE_LO][3:0];
  assign first_slope           = {cfg[CSC_OFS_SLOPE1_HI], cfg[CSC_OFS_SLOPE1_LO][7:2]};  // R5
  assign second_slope          = {cfg[CSC_OFS_SLOPE2_HI], cfg[CSC_OFS_SLOPE2_LO][7:2]};  // R16
  assign control_method_select_handover_en  = cfg[CSC_OFS_SLOPE1_LO][CSC_HANDOVER_BIT];
  assign full_speed_at_zero    = cfg[CSC_OFS_SLOPE1_LO][CSC_FULLZERO_BIT];
  assign control_method_select = cfg[CSC_OFS_SLOPE2_LO][CSC_OLSEL_BIT];

  // Thresholds on the command scale, 512 being full duty
  logic [CMD_W-1:0] start_pt;
  logic [CMD_W-1:0] stop_pt;
  logic [CMD_W-1:0] knee_pt;
  logic [CMD_W-1:0] upper_pt;
  logic [CMD_W-1:0] return_pt;
  logic [5:0]       return_step;

  assign start_pt    = CMD_W'(start_threshold_code);                          // R3
  assign stop_pt     = CMD_W'({stop_threshold_code, 1'b0});                   // R3
  assign knee_pt     = CMD_W'({knee_point_code, 1'b0});                       // R14
  assign upper_pt    = CMD_W'(upper_knee_code) + CMD_W'(CSC_KNEE_OFFSET);     // R2
  // Five-bit sum so a hysteresis code of 15 does not wrap
  assign return_step = {({1'b0, handover_hysteresis} + 5'h01), 1'b0};         // R8
  assign return_pt   = upper_pt - CMD_W'(return_step);                        // R6

  // Command classification
  logic cmd_zero;
  logic cmd_le_stop;
  logic cmd_le_start;
  logic cmd_above_upper;
  logic cmd_at_upper;
  logic cmd_le_return;

  assign cmd_zero        = (speed_command == '0);
  assign cmd_le_stop     = (speed_command <= stop_pt);
  assign cmd_le_start    = (speed_command <= start_pt);
  assign cmd_above_upper = (speed_command > upper_pt);
  assign cmd_at_upper    = (speed_command >= upper_pt);
  assign cmd_le_return   = (speed_command <= return_pt);

  // Curve evaluation point: the upper knee stands in for the maximum speed
  // below start, and clamps the command when hand-over is off
  logic [CMD_W-1:0] eval_pt;
  logic             use_second;
  logic [CMD_W-1:0] span_one;
  logic [CMD_W-1:0] span_two;
  logic [RPM_W-1:0] rise_one;
  logic [RPM_W-1:0] rise_two;
  logic [RPM_W-1:0] curve_rpm;

  assign eval_pt    = (cmd_le_start || (cmd_above_upper && !control_method_select_handover_en)) ?
                      upper_pt : speed_command;                                // R19
  // A knee code of 0 or a doubled knee code below start means a single slope
  assign use_second = (knee_point_code != 8'h00) && (eval_pt > knee_pt) &&
                      (knee_pt >= start_pt);                                   // R14
  assign span_one   = use_second ? (knee_pt - start_pt) : (eval_pt - start_pt);      // R15
  assign span_two   = use_second ? (eval_pt - knee_pt) : '0;                   // R16
  assign curve_rpm  = RPM_W'(base_speed_rpm) + rise_one + rise_two;            // R5

  csc_segment #(
    .SLOPE_W (SLOPE_W),
    .SPAN_W  (CMD_W),
    .OUT_W   (RPM_W)
  ) u_seg_one (
    .slope (first_slope),
    .span  (span_one),
    .rise  (rise_one)
  );

  csc_segment #(
    .SLOPE_W (SLOPE_W),
    .SPAN_W  (CMD_W),
    .OUT_W   (RPM_W)
  ) u_seg_two (
    .slope (second_slope),
    .span  (span_two),
    .rise  (rise_two)
  );

  // Low-command selection; direction is this cycle's compare, so a turn acts without lag
  logic pick_max;
  logic pick_base;

  assign pick_max  = cmd_le_start && full_speed_at_zero &&
                     (cmd_zero || (keep_running_low_cmd && cmd_le_stop));      // R11
  assign pick_base = cmd_le_start && !pick_max &&
                     (keep_running_low_cmd || (!cmd_le_stop && next_falling)); // R10
  assign next_falling = (speed_command < prev_cmd) ? 1'b1 :
                        (speed_command > prev_cmd) ? 1'b0 : falling;           // R9

  // Target selection
  always_comb begin
    next_target = '0;
    next_full   = 1'b0;
    if (control_method_select) begin
      next_target = '0;                                                        // R1
    end else if (loop_state == CSC_DIRECT) begin
      next_target = curve_rpm;
    end else if (pick_max) begin
      next_target = curve_rpm;
      next_full   = control_method_select_handover_en;                                      // R12
    end else if (pick_base) begin
      next_target = RPM_W'(base_speed_rpm);                                    // R10
    end else if (cmd_le_start) begin
      next_target = '0;                                                        // R9
    end else begin
      next_target = curve_rpm;                                                 // R18
    end
  end

  // Hand-over with hysteresis, so a command hovering at the knee cannot chatter
  always_comb begin
    next_loop_state = loop_state;
    unique case (loop_state)
      CSC_CLOSED: begin
        if (!control_method_select && control_method_select_handover_en && cmd_at_upper) begin
          next_loop_state = CSC_DIRECT;                                        // R2
        end
      end
      CSC_DIRECT: begin
        if (control_method_select || !control_method_select_handover_en || cmd_le_return) begin
          next_loop_state = CSC_CLOSED;                                        // R6
        end
      end
      default: begin
        next_loop_state = CSC_CLOSED;
      end
    endcase
  end

  // Configuration writes at the printed offsets; other addresses are ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = CSC_CFG_FIRST; i <= CSC_CFG_LAST; i++) begin
        cfg[i] <= CSC_CFG_RST;
      end
    end else if (reg_we && (int'(reg_addr) >= CSC_CFG_FIRST) && (int'(reg_addr) <= CSC_CFG_LAST)) begin
      cfg[int'(reg_addr)] <= reg_wdata;
    end
  end

  // Read port, one cycle behind the address; unmapped addresses read zero
  logic [7:0] rd_mux;
  assign rd_mux = ((int'(reg_addr) >= CSC_CFG_FIRST) && (int'(reg_addr) <= CSC_CFG_LAST)) ?
                  cfg[int'(reg_addr)] :
                  (reg_addr == CSC_OFS_STATUS) ? {6'h00, falling, (loop_state == CSC_DIRECT)} : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  // Curve outputs, registered so downstream sees a clean value
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      target_rpm   <= '0;
      full_output  <= 1'b0;
      curve_active <= 1'b0;
      loop_state   <= CSC_CLOSED;
      prev_cmd     <= '0;
      falling      <= 1'b0;
    end else begin
      target_rpm   <= next_target;
      full_output  <= next_full;
      curve_active <= !control_method_select;                                  // R1
      loop_state   <= next_loop_state;
      prev_cmd     <= speed_command;
      falling      <= next_falling;
    end
  end

  assign direct_follow = (loop_state == CSC_DIRECT);                           // R13

  // Reference curve for the checks, worked out independently of the datapath
  logic [27:0]      ref_prod_one;
  logic [27:0]      ref_prod_knee;
  logic [27:0]      ref_prod_two;
  logic [27:0]      ref_prod_clamp;
  logic [RPM_W-1:0] ref_single;
  logic [RPM_W-1:0] ref_double;
  logic [RPM_W-1:0] ref_clamp;
  logic             closed_run;

  assign ref_prod_one   = 28'(first_slope) * 28'(speed_command - start_pt);
  assign ref_prod_knee  = 28'(first_slope) * 28'(knee_pt - start_pt);
  assign ref_prod_two   = 28'(second_slope) * 28'(speed_command - knee_pt);
  assign ref_prod_clamp = 28'(first_slope) * 28'(upper_pt - start_pt);
  assign ref_single     = RPM_W'(base_speed_rpm) + RPM_W'(ref_prod_one >> 6);
  assign ref_double     = RPM_W'(base_speed_rpm) + RPM_W'(ref_prod_knee >> 6) + RPM_W'(ref_prod_two >> 6);
  assign ref_clamp      = RPM_W'(base_speed_rpm) + RPM_W'(ref_prod_clamp >> 6);
  assign closed_run     = !control_method_select && (loop_state == CSC_CLOSED);

  property p_open_select;
    @(posedge clk) disable iff (sys_rst)
      control_method_select |=> (target_rpm == '0) && !curve_active && !full_output;
  endproperty
  a_open_select: assert property (p_open_select) // R1
    else $error("Open-loop select did not park the curve");

  property p_enter_direct;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && control_method_select_handover_en && (speed_command == upper_pt)) |=> direct_follow;
  endproperty
  a_enter_direct: assert property (p_enter_direct) // R2
    else $error("No hand-over at the upper knee");

  property p_return_closed;
    @(posedge clk) disable iff (sys_rst)
      (direct_follow && !control_method_select && control_method_select_handover_en &&
       (speed_command == upper_pt - CMD_W'({({1'b0, handover_hysteresis} + 5'h01), 1'b0})))
      |=> !direct_follow;
  endproperty
  a_return_closed: assert property (p_return_closed) // R6
    else $error("No return to closed loop at the return point");

  property p_hold_direct;
    @(posedge clk) disable iff (sys_rst)
      (direct_follow && !control_method_select && control_method_select_handover_en &&
       (speed_command > return_pt)) |=> direct_follow;
  endproperty
  a_hold_direct: assert property (p_hold_direct) // R8
    else $error("Hand-over dropped inside the hysteresis band");

  property p_single_slope;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && (knee_point_code == 8'h00) && (speed_command > start_pt) &&
       (speed_command <= upper_pt)) |=> (target_rpm == $past(ref_single));
  endproperty
  a_single_slope: assert property (p_single_slope) // R5
    else $error("Single-slope target is wrong");

  property p_two_slope;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && (knee_point_code != 8'h00) && (knee_pt >= start_pt) &&
       (speed_command > knee_pt) && (speed_command <= upper_pt)) |=> (target_rpm == $past(ref_double));
  endproperty
  a_two_slope: assert property (p_two_slope) // R16
    else $error("Second-slope target is wrong");

  property p_clamp;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && !control_method_select_handover_en && (knee_point_code == 8'h00) && cmd_above_upper)
      |=> (target_rpm == $past(ref_clamp));
  endproperty
  a_clamp: assert property (p_clamp) // R19
    else $error("Target not clamped above the upper knee");

  property p_stop_zero;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && !keep_running_low_cmd && !cmd_zero && cmd_le_stop) |=> (target_rpm == '0) && !full_output;
  endproperty
  a_stop_zero: assert property (p_stop_zero) // R11
    else $error("Command below stop did not give zero");

  property p_between_dir;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && !keep_running_low_cmd && !cmd_le_stop && cmd_le_start && (speed_command < prev_cmd))
      |=> (target_rpm == RPM_W'($past(base_speed_rpm)));
  endproperty
  a_between_dir: assert property (p_between_dir) // R9
    else $error("Falling command between stop and start not at base speed");

  property p_keep_base;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && keep_running_low_cmd && !cmd_le_stop && cmd_le_start)
      |=> (target_rpm == RPM_W'($past(base_speed_rpm)));
  endproperty
  a_keep_base: assert property (p_keep_base) // R10
    else $error("Keep-running did not give base speed");

  property p_zero_full;
    @(posedge clk) disable iff (sys_rst)
      (closed_run && full_speed_at_zero && control_method_select_handover_en && cmd_zero) |=> full_output ##1 1'b1;
  endproperty
  a_zero_full: assert property (p_zero_full) // R12
    else $error("Zero command with hand-over did not drive full output");

  c_enter_direct: cover property (@(posedge clk) disable iff (sys_rst) !direct_follow ##1 direct_follow);
  c_leave_direct: cover property (@(posedge clk) disable iff (sys_rst) direct_follow ##1 !direct_follow);
  c_two_slope:    cover property (@(posedge clk) disable iff (sys_rst) closed_run && use_second);
  c_full_output:  cover property (@(posedge clk) disable iff (sys_rst) full_output);

endmodule : csc_speed_curve

/* sim/csc_host_model.sv */
// Host side: drives the speed command and programs the curve over the register port
module csc_host_model
  import csc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [9:0] speed_command,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_we
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet bus from time zero
  initial begin
    speed_command = 10'h000;
    reg_addr      = 8'h00;
    reg_wdata     = 8'h00;
    reg_we        = 1'b0;
  end

  // One write, changed after a falling edge and taken at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'b1;
    @(negedge clk);
    reg_we    = 1'b0;
    reg_wdata = ~d; // Released data must not look valid
  endtask : wr

  // Read data lags the address by one rising edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // New command level, held until the next call
  task automatic cmd(input logic [9:0] c);
    @(negedge clk);
    speed_command = c;
  endtask : cmd

  // Full curve setup: start 102, stop 46, upper code 204, base 1500, hysteresis 9
  task automatic load(input logic keep, input logic [7:0] knee, input logic [7:0] s1_hi,
                      input logic [7:0] s1_lo, input logic [7:0] s2_hi, input logic [7:0] s2_lo);
    wr(CSC_OFS_STOP, {keep, 7'h2e});
    wr(CSC_OFS_START, 8'h66);
    wr(CSC_OFS_KNEE, knee);
    wr(CSC_OFS_UPPER, 8'hcc);
    wr(CSC_OFS_BASE_HI, 8'h5d);
    wr(CSC_OFS_BASE_LO, 8'hc9);
    wr(CSC_OFS_SLOPE1_HI, s1_hi);
    wr(CSC_OFS_SLOPE1_LO, s1_lo);
    wr(CSC_OFS_SLOPE2_HI, s2_hi);
    wr(CSC_OFS_SLOPE2_LO, s2_lo);
  endtask : load
endmodule : csc_host_model

/* sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csc_pkg::*;

  logic        clk;
  logic        sys_rst;
  logic [9:0]  speed_command;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic [7:0]  reg_rdata;
  logic [18:0] target_rpm;
  logic        full_output;
  logic        direct_follow;
  logic        curve_active;
  int          num_errors;
  int          checks;

  csc_speed_curve dut_u (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .speed_command (speed_command),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_we        (reg_we),
    .reg_rdata     (reg_rdata),
    .target_rpm    (target_rpm),
    .full_output   (full_output),
    .direct_follow (direct_follow),
    .curve_active  (curve_active)
  );

  csc_host_model host_u (
    .clk           (clk),
    .reg_rdata     (reg_rdata),
    .speed_command (speed_command),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_we        (reg_we)
  );

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Command change, then wait past the one-cycle output latency
  task automatic go(input logic [9:0] c);
    host_u.cmd(c);
    repeat (3) @(negedge clk);
  endtask : go

  task automatic print_verdict();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Reset contents, readback, unmapped and read-only places
  task automatic t_regs();
    logic [7:0] d;
    for (int a = CSC_CFG_FIRST; a <= CSC_CFG_LAST; a++) begin
      host_u.rd(a[7:0], d);
      check(d, CSC_CFG_RST);
    end
    check(curve_active, 1'b1);
    check(target_rpm, 0);
    host_u.wr(CSC_OFS_BASE_HI, 8'h5a);
    host_u.rd(CSC_OFS_BASE_HI, d);
    check(d, 8'h5a);
    host_u.wr(8'h30, 8'hff);
    host_u.rd(8'h30, d);
    check(d, 8'h00);
    host_u.wr(CSC_OFS_STATUS, 8'hff);
    host_u.rd(CSC_OFS_STATUS, d);
    check(d, 8'h00);
    $display("test regs done");
  endtask : t_regs

  // Single slope 2407, clamp above the upper knee, edges of start and stop
  task automatic t_curve();
    host_u.load(1'b0, 8'h00, 8'h25, 8'h9c, 8'h00, 8'h00);
    go(10'd200);
    check(target_rpm, 5185);
    go(10'd461);
    check(target_rpm, 15001);
    go(10'd470);
    check(target_rpm, 15001);
    check(direct_follow, 1'b0);
    go(10'd103);
    check(target_rpm, 1537);
    go(10'd102);
    check(target_rpm, 1500);
    go(10'd92);
    check(target_rpm, 0);
    go(10'd93);
    check(target_rpm, 0);
    $display("test curve done");
  endtask : t_curve

  // Low-command options, without and with hand-over
  task automatic t_low();
    host_u.wr(CSC_OFS_STOP, 8'hae);
    go(10'd0);
    check(target_rpm, 1500);
    go(10'd50);
    check(target_rpm, 1500);
    go(10'd100);
    check(target_rpm, 1500);
    host_u.wr(CSC_OFS_SLOPE1_LO, 8'h9d);
    go(10'd0);
    check(target_rpm, 15001);
    go(10'd50);
    check(target_rpm, 15001);
    host_u.wr(CSC_OFS_STOP, 8'h2e);
    go(10'd0);
    check(target_rpm, 15001);
    check(full_output, 1'b0);
    go(10'd10);
    check(target_rpm, 0);
    host_u.wr(CSC_OFS_SLOPE1_LO, 8'h9f);
    go(10'd0);
    check(full_output, 1'b1);
    go(10'd10);
    check(full_output, 1'b0);
    $display("test low done");
  endtask : t_low

  // Hand-over enters at 461 and returns at 461 - (9 + 1) * 2 = 441
  task automatic t_handover();
    logic [7:0] d;
    host_u.wr(CSC_OFS_SLOPE1_LO, 8'h9e);
    go(10'd460);
    check(direct_follow, 1'b0);
    go(10'd461);
    check(direct_follow, 1'b1);
    go(10'd442);
    check(direct_follow, 1'b1);
    host_u.rd(CSC_OFS_STATUS, d);
    check(d, 8'h03);
    go(10'd441);
    check(direct_follow, 1'b0);
    $display("test handover done");
  endtask : t_handover

  // Two slopes 1455 and 3122 split at 256, with hand-over kept on
  task automatic t_knee();
    host_u.load(1'b0, 8'h80, 8'h16, 8'hbe, 8'h30, 8'hc8);
    go(10'd256);
    check(target_rpm, 5001);
    go(10'd300);
    check(target_rpm, 7147);
    go(10'd461);
    check(direct_follow, 1'b1);
    go(10'd300);
    check(direct_follow, 1'b0);
    $display("test knee done");
  endtask : t_knee

  // Open-loop select parks the closed-loop curve
  task automatic t_method();
    host_u.wr(CSC_OFS_SLOPE2_LO, 8'hc9);
    go(10'd300);
    check(curve_active, 1'b0);
    check(target_rpm, 0);
    host_u.wr(CSC_OFS_SLOPE2_LO, 8'hc8);
    go(10'd300);
    check(target_rpm, 7147);
    $display("test method done");
  endtask : t_method

  // Mid-run reset drops the hand-over state and clears the configuration
  task automatic t_reset();
    logic [7:0] d;
    go(10'd461);
    check(direct_follow, 1'b1);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check(target_rpm, 0);
    check(direct_follow, 1'b0);
    host_u.rd(CSC_OFS_UPPER, d);
    check(d, CSC_CFG_RST);
    check(direct_follow, 1'b0);
    $display("test reset done");
  endtask : t_reset

  // Main sequence, reset held for eight cycles
  initial begin
    num_errors = 0;
    checks     = 0;
    sys_rst    = 1'b1;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_curve();
    t_low();
    t_handover();
    t_knee();
    t_method();
    t_reset();
    print_verdict();
  end

  // Watchdog: the tests need well under 2000 cycles
  initial begin
    #250000;
    num_errors++;
    print_verdict();
  end
endmodule : tb
